/* File: design/vectored_interrupt_resolver.sv */
// Overview of operation
// RL1: within one level the pending source with lowest vector wins, fixed
// RL2: intra-level priority index zero is highest, larger is lower
// RL3: external pins set pending on rising or falling edge per setting
// RL4: reset start address 0100h unless option selects alternate address
// RL5: vectors fetched from bottom of 16KB program memory, 0h-3FFFh
// RL6: enable instruction sets system mode bit 0, disable clears it
// RL7: with global enable, unmasked pending requests serviced by priority
// RL8: disable instruction blocks further interrupts until enable again
// RL9: startup software must execute global enable; interrupts start off
// RL10: level five carries two serial ports' transmit/receive, E8h to EEh
// RL11: level six carries pins at F0h, F2h, F4h, F6h, software clear
// RL12: level seven carries pins at F8h, FAh, FCh, FEh, software clear
// RL13: levels zero to four carry timers, serial interface, watch timer
// RL14: active levels ordered by level priority register first
// RL15: grant disables interrupts, pushes state, fetches two vector bytes
// RL16: pending flag cleared by hardware on service or left to software
// RL17: level mask enables or blocks each of eight levels
// RL18: source with peripheral enable clear is never presented
module vectored_interrupt_resolver
#(
   parameter int NSRC = irq_resolver_pkg::NUM_SRC,
   parameter int NLVL = irq_resolver_pkg::NUM_LEVEL
) (
   input  wire logic                               clk,
   input  wire logic                               rst_n,
   input  wire logic [13:0]                        periph_event,
   input  wire logic [NSRC-1:0]                    src_enable,
   input  wire logic [NSRC-1:0]                    sw_pend_clear,
   input  wire logic [irq_resolver_pkg::NUM_PIN-1:0] ext_pin,
   input  wire logic [irq_resolver_pkg::NUM_PIN-1:0] ext_rising_sel,
   input  wire logic [NLVL-1:0]                    level_mask_reg,
   input  wire logic [NLVL*3-1:0]                  level_priority_reg,
   input  wire logic                               global_irq_enable_instr,
   input  wire logic                               global_irq_disable_instr,
   input  wire logic                               reset_addr_opt,
   input  wire logic [15:0]                        reset_addr_alt,
   input  wire logic                               cpu_ack,
   input  wire logic [7:0]                         rom_rdata,
   output irq_resolver_pkg::irq_request_t          cpu_req,
   output irq_resolver_pkg::rom_fetch_t            rom_fetch,
   output logic                                    push_context,
   output logic                                    service_valid,
   output logic [15:0]                             service_addr,
   output logic [15:0]                             reset_pc,
   output logic [7:0]                              system_mode_reg,
   output logic [NLVL-1:0]                         level_pending,
   output logic [NSRC-1:0]                         src_pending
);

   // lowest set bit; lower index means higher priority
   function automatic logic [irq_resolver_pkg::SRC_W:0] first_set(
      input logic [NSRC-1:0] v);
      logic [irq_resolver_pkg::SRC_W:0] r;
      r = '0;
      for (int i = NSRC - 1; i >= 0; i--) begin
         if (v[i]) begin
            r = {1'b1, i[irq_resolver_pkg::SRC_W-1:0]};
         end
      end
      return r;
   endfunction

   function automatic logic [NSRC-1:0] level_members(
      input logic [irq_resolver_pkg::LEVEL_W-1:0] lvl);
      logic [NSRC-1:0] m;
      m = '0;
      for (int i = 0; i < NSRC; i++) begin
         m[i] = (irq_resolver_pkg::SRC_LEVEL[i] == lvl);
      end
      return m;
   endfunction

   // ---------------- external pin edges
   logic [irq_resolver_pkg::NUM_PIN-1:0] pin_rise;
   logic [irq_resolver_pkg::NUM_PIN-1:0] pin_fall;
   logic [irq_resolver_pkg::NUM_PIN-1:0] pin_event;
   pin_edge_sync #(
      .WIDTH (irq_resolver_pkg::NUM_PIN)
   ) u_pin_sync (
      .clk   (clk),
      .rst_n (rst_n),
      .pin   (ext_pin),
      .rise  (pin_rise),
      .fall  (pin_fall)
   );

   always_comb begin
      pin_event = (pin_rise & ext_rising_sel)
                | (pin_fall & ~ext_rising_sel); // RL3
   end

   // ---------------- pending flags
   logic [NSRC-1:0] pend_reg;
   logic [NSRC-1:0] pend_next;
   logic [NSRC-1:0] set_vec;
   logic [NSRC-1:0] hw_clr_vec;
   logic [NSRC-1:0] eligible;
   irq_resolver_pkg::grant_state_t   state_reg;
   irq_resolver_pkg::grant_state_t   state_next;
   logic [irq_resolver_pkg::SRC_W-1:0] win_src_reg;
   logic [irq_resolver_pkg::SRC_W-1:0] win_src_next;

   always_comb begin
      set_vec    = {pin_event, periph_event}; // RL10 RL11 RL12 RL13
      hw_clr_vec = '0;
      if (state_reg == irq_resolver_pkg::ST_PRESENT && cpu_ack) begin
         hw_clr_vec[win_src_reg] =
            irq_resolver_pkg::SRC_HW_CLEAR[win_src_reg]; // RL16
      end
      // a new event in the clearing cycle is kept
      pend_next = (pend_reg & ~(sw_pend_clear | hw_clr_vec)) | set_vec;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pend_reg <= '0;
      end else begin
         pend_reg <= pend_next;
      end
   end

   // ---------------- global enable
   logic [7:0] mode_reg;
   logic [7:0] mode_next;

   always_comb begin
      mode_next = mode_reg;
      if (global_irq_enable_instr) begin
         mode_next[irq_resolver_pkg::MODE_GIE_BIT] = 1'b1; // RL6
      end
      // disable beats enable; grant beats both
      if (global_irq_disable_instr) begin
         mode_next[irq_resolver_pkg::MODE_GIE_BIT] = 1'b0; // RL6 RL8
      end
      if (state_reg == irq_resolver_pkg::ST_PRESENT && cpu_ack) begin
         mode_next[irq_resolver_pkg::MODE_GIE_BIT] = 1'b0; // RL15
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mode_reg <= irq_resolver_pkg::MODE_RESET; // RL9
      end else begin
         mode_reg <= mode_next;
      end
   end

   // ---------------- arbitration
   logic [NLVL-1:0]    lvl_active;
   logic               any_level;
   logic [irq_resolver_pkg::LEVEL_W-1:0] best_lvl;
   logic [2:0]                           best_rank;
   logic [irq_resolver_pkg::SRC_W:0]     pick;

   always_comb begin
      eligible  = pend_reg & src_enable; // RL18
      any_level = 1'b0;
      best_lvl  = '0;
      best_rank = 3'h7;
      for (int l = 0; l < NLVL; l++) begin
         lvl_active[l] = |(eligible
            & level_members(l[irq_resolver_pkg::LEVEL_W-1:0]));
      end
      // lower rank value wins, ties go to lower level number
      for (int l = 0; l < NLVL; l++) begin
         if (lvl_active[l] && level_mask_reg[l]) begin // RL17
            if (!any_level ||
                level_priority_reg[l*3 +: 3] < best_rank) begin // RL14
               any_level = 1'b1;
               best_lvl  = l[irq_resolver_pkg::LEVEL_W-1:0];
               best_rank = level_priority_reg[l*3 +: 3];
            end
         end
      end
      pick = first_set(eligible & level_members(best_lvl)); // RL1 RL2
   end

   // ---------------- grant sequence
   logic [7:0]  vec_reg;
   logic [7:0]  vec_next;
   logic [7:0]  hi_reg;
   logic [7:0]  hi_next;
   logic [15:0] svc_reg;
   logic [15:0] svc_next;
   logic        req_ok;

   always_comb begin
      req_ok       = mode_reg[irq_resolver_pkg::MODE_GIE_BIT] && any_level
                     && pick[irq_resolver_pkg::SRC_W]; // RL7
      state_next   = state_reg;
      win_src_next = win_src_reg;
      vec_next     = vec_reg;
      hi_next      = hi_reg;
      svc_next     = svc_reg;
      case (state_reg)
         irq_resolver_pkg::ST_IDLE: begin
            if (req_ok) begin
               win_src_next = pick[irq_resolver_pkg::SRC_W-1:0];
               state_next   = irq_resolver_pkg::ST_PRESENT;
            end
         end
         irq_resolver_pkg::ST_PRESENT: begin
            if (cpu_ack) begin
               vec_next   = irq_resolver_pkg::SRC_VECTOR[win_src_reg];
               state_next = irq_resolver_pkg::ST_FETCH_H;
            end else if (!req_ok) begin
               // withdrawn by disable, mask or clear before acceptance
               state_next = irq_resolver_pkg::ST_IDLE; // RL8
            end else begin
               win_src_next = pick[irq_resolver_pkg::SRC_W-1:0];
            end
         end
         irq_resolver_pkg::ST_FETCH_H: begin
            state_next = irq_resolver_pkg::ST_FETCH_L;
         end
         irq_resolver_pkg::ST_FETCH_L: begin
            hi_next    = rom_rdata;
            state_next = irq_resolver_pkg::ST_DONE;
         end
         irq_resolver_pkg::ST_DONE: begin
            svc_next   = {hi_reg, rom_rdata}; // RL15
            state_next = irq_resolver_pkg::ST_IDLE;
         end
         default: begin
            state_next = irq_resolver_pkg::ST_IDLE;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state_reg   <= irq_resolver_pkg::ST_IDLE;
         win_src_reg <= '0;
         vec_reg     <= '0;
         hi_reg      <= '0;
         svc_reg     <= '0;
      end else begin
         state_reg   <= state_next;
         win_src_reg <= win_src_next;
         vec_reg     <= vec_next;
         hi_reg      <= hi_next;
         svc_reg     <= svc_next;
      end
   end

   // ---------------- output registers
   irq_resolver_pkg::irq_request_t req_reg;
   irq_resolver_pkg::irq_request_t req_next;
   irq_resolver_pkg::rom_fetch_t   fetch_reg;
   irq_resolver_pkg::rom_fetch_t   fetch_next;
   logic         push_reg;
   logic         push_next;
   logic         svc_valid_reg;
   logic         svc_valid_next;

   always_comb begin
      req_next        = '0;
      fetch_next      = '0;
      push_next       = 1'b0;
      svc_valid_next  = (state_reg == irq_resolver_pkg::ST_DONE);
      if (state_next == irq_resolver_pkg::ST_PRESENT) begin
         req_next.valid  = 1'b1;
         req_next.vector = irq_resolver_pkg::SRC_VECTOR[win_src_next];
         req_next.level  = irq_resolver_pkg::SRC_LEVEL[win_src_next];
         req_next.prio   = irq_resolver_pkg::SRC_PRIO[win_src_next]; // RL2
      end
      if (state_reg == irq_resolver_pkg::ST_PRESENT && cpu_ack) begin
         push_next       = 1'b1; // RL15
         // vector byte, then the byte after it, both inside program rom
         fetch_next.rd   = 1'b1; // RL5
         fetch_next.addr = {6'h00, irq_resolver_pkg::SRC_VECTOR[win_src_reg]}
                         & irq_resolver_pkg::ROM_LAST_ADDR[13:0];
      end
      if (state_reg == irq_resolver_pkg::ST_FETCH_H) begin
         fetch_next.rd   = 1'b1;
         fetch_next.addr = ({6'h00, vec_reg} + 14'h0001)
                         & irq_resolver_pkg::ROM_LAST_ADDR[13:0]; // RL5
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         req_reg       <= '0;
         fetch_reg     <= '0;
         push_reg      <= 1'b0;
         svc_valid_reg <= 1'b0;
      end else begin
         req_reg       <= req_next;
         fetch_reg     <= fetch_next;
         push_reg      <= push_next;
         svc_valid_reg <= svc_valid_next;
      end
   end

   // ---------------- reset start address
   // option strap is sampled once, on the first edge after release
   logic [15:0] rst_pc_reg;
   logic [15:0] rst_pc_next;
   logic        strap_done_reg;
   logic        strap_done_next;
   always_comb begin
      rst_pc_next     = rst_pc_reg;
      strap_done_next = 1'b1;
      if (!strap_done_reg) begin
         rst_pc_next = reset_addr_opt ? reset_addr_alt
                                      : irq_resolver_pkg::RESET_ADDR; // RL4
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_pc_reg     <= irq_resolver_pkg::RESET_ADDR; // RL4
         strap_done_reg <= 1'b0;
      end else begin
         rst_pc_reg     <= rst_pc_next;
         strap_done_reg <= strap_done_next;
      end
   end

   // ---------------- level request view
   logic [NLVL-1:0] lvl_pend_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         lvl_pend_reg <= '0;
      end else begin
         lvl_pend_reg <= lvl_active;
      end
   end

   assign cpu_req         = req_reg;
   assign rom_fetch       = fetch_reg;
   assign push_context    = push_reg;
   assign service_valid   = svc_valid_reg;
   assign service_addr    = svc_reg;
   assign reset_pc        = rst_pc_reg;
   assign system_mode_reg = mode_reg;
   assign level_pending   = lvl_pend_reg;
   assign src_pending     = pend_reg;

endmodule

/* File: design/irq_resolver_pkg.sv */
package irq_resolver_pkg;

   localparam int NUM_SRC    = 22;
   localparam int NUM_LEVEL  = 8;
   localparam int NUM_PIN    = 8;
   localparam int SRC_W      = 5;
   localparam int LEVEL_W    = 3;
   localparam int PRIO_W     = 2;
   localparam int ADDR_W     = 14;

   // internal program memory bounds, vectors live at its bottom
   localparam logic [15:0] ROM_LAST_ADDR  = 16'h3FFF;
   localparam logic [15:0] RESET_ADDR     = 16'h0100;
   localparam logic [7:0]  VECTOR_FIRST   = 8'hCE;

   // global enable sits in bit 0 of the system mode register
   localparam int          MODE_GIE_BIT   = 0;
   localparam logic [7:0]  MODE_RESET     = 8'h00;
   localparam logic [7:0]  LEVEL_MASK_RST = 8'h00;

   // first source index fed by external pins
   localparam int          PIN_SRC_BASE   = 14;

   // vector byte address per source, index order equals priority order
   localparam logic [NUM_SRC-1:0][7:0] SRC_VECTOR = {
      8'hFE, 8'hFC, 8'hFA, 8'hF8,
      8'hF6, 8'hF4, 8'hF2, 8'hF0,
      8'hEE, 8'hEC, 8'hEA, 8'hE8,
      8'hE6, 8'hE4,
      8'hDE, 8'hDC, 8'hDA, 8'hD8,
      8'hD4, 8'hD2, 8'hD0, VECTOR_FIRST
   };

   localparam logic [NUM_SRC-1:0][LEVEL_W-1:0] SRC_LEVEL = {
      3'h7, 3'h7, 3'h7, 3'h7,
      3'h6, 3'h6, 3'h6, 3'h6,
      3'h5, 3'h5, 3'h5, 3'h5,
      3'h4, 3'h4,
      3'h3, 3'h3, 3'h3, 3'h3,
      3'h2, 3'h1, 3'h0, 3'h0
   };

   // priority in level, 0 highest
   localparam logic [NUM_SRC-1:0][PRIO_W-1:0] SRC_PRIO = {
      2'h3, 2'h2, 2'h1, 2'h0,
      2'h3, 2'h2, 2'h1, 2'h0,
      2'h3, 2'h2, 2'h1, 2'h0,
      2'h1, 2'h0,
      2'h3, 2'h2, 2'h1, 2'h0,
      2'h0, 2'h0, 2'h1, 2'h0
   };

   // timer sources are cleared by hardware when serviced
   localparam logic [NUM_SRC-1:0] SRC_HW_CLEAR = 22'h0000FF;

   typedef enum logic [4:0] {
      ST_IDLE    = 5'h01,
      ST_PRESENT = 5'h02,
      ST_FETCH_H = 5'h04,
      ST_FETCH_L = 5'h08,
      ST_DONE    = 5'h10
   } grant_state_t;

   typedef struct packed {
      logic               valid;
      logic [7:0]         vector;
      logic [LEVEL_W-1:0] level;
      logic [PRIO_W-1:0]  prio;
   } irq_request_t;

   typedef struct packed {
      logic              rd;
      logic [ADDR_W-1:0] addr;
   } rom_fetch_t;

endpackage

/* File: design/pin_edge_sync.sv */
module pin_edge_sync #(
   parameter int WIDTH = 8
) (
   input  wire logic             clk,
   input  wire logic             rst_n,
   input  wire logic [WIDTH-1:0] pin,
   output logic      [WIDTH-1:0] rise,
   output logic      [WIDTH-1:0] fall
);

   logic [WIDTH-1:0] s1_reg;
   logic [WIDTH-1:0] s2_reg;
   logic [WIDTH-1:0] s3_reg;
   logic [WIDTH-1:0] level_reg;
   logic [WIDTH-1:0] level_next;
   logic [WIDTH-1:0] agree;

   // a change is only accepted once stages two and three agree
   always_comb begin
      agree      = ~(s2_reg ^ s3_reg);
      level_next = (agree & s3_reg) | (~agree & level_reg);
      rise       = agree & s3_reg & ~level_reg;
      fall       = agree & ~s3_reg & level_reg;
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         s1_reg    <= '0;
         s2_reg    <= '0;
         s3_reg    <= '0;
         level_reg <= '0;
      end else begin
         s1_reg    <= pin;
         s2_reg    <= s1_reg;
         s3_reg    <= s2_reg;
         level_reg <= level_next;
      end
   end

endmodule

/* File: verif/irq_resolver_properties.sv */
module irq_resolver_properties (
   input logic                           clk,
   input logic                           rst_n,
   input logic                           global_irq_enable_instr,
   input logic                           global_irq_disable_instr,
   input logic                           cpu_ack,
   input logic [7:0]                     rom_rdata,
   input logic                           push_context,
   input logic                           service_valid,
   input logic [15:0]                    service_addr,
   input logic [15:0]                    reset_pc,
   input logic [15:0]                    reset_addr_alt,
   input logic                           reset_addr_opt,
   input logic [7:0]                     system_mode_reg,
   input logic [21:0]                    src_pending,
   input logic [21:0]                    sw_pend_clear,
   input irq_resolver_pkg::irq_request_t cpu_req,
   input irq_resolver_pkg::rom_fetch_t   rom_fetch
);
   timeunit 1ns;
   timeprecision 1ns;
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);

   a_reset_pc: assert property ($past(rst_n) |-> reset_pc ==
      (reset_addr_opt ? reset_addr_alt : 16'h0100))
      else $error("reset address wrong");
   a_gie_needed: assert property (cpu_req.valid |->
      $past(system_mode_reg[0])) else $error("request while disabled");
   a_enable_sets: assert property (global_irq_enable_instr &&
      !global_irq_disable_instr && !cpu_ack |=> system_mode_reg[0])
      else $error("enable bit not set");
   a_disable_wins: assert property (global_irq_disable_instr |=>
      !system_mode_reg[0]) else $error("enable bit not cleared");
   a_ack_fetch: assert property (cpu_ack && cpu_req.valid |=>
      push_context && !cpu_req.valid && !system_mode_reg[0] &&
      rom_fetch.rd && rom_fetch.addr == {6'h00, $past(cpu_req.vector)})
      else $error("grant start wrong");
   a_fetch_second: assert property (push_context |=> rom_fetch.rd &&
      rom_fetch.addr == $past(rom_fetch.addr) + 14'h0001 ##2 service_valid)
      else $error("second fetch wrong");
   a_service_addr: assert property (service_valid |->
      service_addr == {$past(rom_rdata, 2), $past(rom_rdata)})
      else $error("service address wrong");
   a_sw_kept: assert property (push_context |->
      ($past(src_pending[21:8]) & ~src_pending[21:8] &
      ~$past(sw_pend_clear[21:8])) == 14'h0000)
      else $error("software-cleared flag lost");
endmodule

bind vectored_interrupt_resolver irq_resolver_properties props_inst (
   .clk, .rst_n, .global_irq_enable_instr, .global_irq_disable_instr,
   .cpu_ack, .rom_rdata, .push_context, .service_valid, .service_addr,
   .reset_pc, .reset_addr_alt, .reset_addr_opt, .system_mode_reg,
   .src_pending, .sw_pend_clear, .cpu_req, .rom_fetch
);

/* File: verif/cpu_core_model.sv */
module cpu_core_model (
   input  logic                           clk,
   input  logic                           rst_n,
   input  logic [1:0]                     ack_wait,
   input  irq_resolver_pkg::irq_request_t cpu_req,
   input  irq_resolver_pkg::rom_fetch_t   rom_fetch,
   output logic                           cpu_ack,
   output logic [7:0]                     rom_rdata
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [1:0] cnt_reg;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         cnt_reg   <= 2'h0;
         cpu_ack   <= 1'b0;
         rom_rdata <= 8'h00;
      end else begin
         // ack only a standing request, after ack_wait idle cycles
         cpu_ack <= cpu_req.valid && !cpu_ack && cnt_reg == ack_wait;
         cnt_reg <= (cpu_req.valid && !cpu_ack) ? cnt_reg + 2'h1 : 2'h0;
         // idle cycles show the inverse so stale bytes cannot pass
         rom_rdata <= rom_fetch.rd ? rom_fetch.addr[7:0] ^ 8'h5A
                                   : ~rom_rdata;
      end
   end
endmodule

/* File: verif/tb_top.sv */
module tb_top;
   timeunit 1ns;
   timeprecision 1ns;
   logic        clk = 1'b0;
   logic        rst_n = 1'b0;
   logic [13:0] periph_event = 14'h0000;
   logic [21:0] src_enable = 22'h3FFFFF;
   logic [21:0] sw_pend_clear = 22'h000000;
   logic [7:0]  ext_pin = 8'h00;
   logic [7:0]  ext_rising_sel = 8'hFF;
   logic [7:0]  level_mask_reg = 8'hFF;
   logic [23:0] level_priority_reg = 24'h000000;
   logic        global_irq_enable_instr = 1'b0;
   logic        global_irq_disable_instr = 1'b0;
   logic        reset_addr_opt = 1'b0;
   logic [15:0] reset_addr_alt = 16'h0000;
   logic [1:0]  ack_wait = 2'h0;
   logic        cpu_ack;
   logic [7:0]  rom_rdata;
   logic        push_context;
   logic        service_valid;
   logic [15:0] service_addr;
   logic [15:0] reset_pc;
   logic [7:0]  system_mode_reg;
   logic [21:0] src_pending;
   logic [7:0]  level_pending;
   int          failures = 0;
   int          total_checks = 0;
   irq_resolver_pkg::irq_request_t cpu_req;
   irq_resolver_pkg::rom_fetch_t   rom_fetch;
   localparam logic [7:0] VT [14] = '{8'hCE, 8'hD0, 8'hD2, 8'hD4, 8'hD8,
      8'hDA, 8'hDC, 8'hDE, 8'hE4, 8'hE6, 8'hE8, 8'hEA, 8'hEC, 8'hEE};

   always #50 clk = ~clk;

   vectored_interrupt_resolver vectored_interrupt_resolver_inst (
      .clk, .rst_n, .periph_event, .src_enable, .sw_pend_clear, .ext_pin,
      .ext_rising_sel, .level_mask_reg, .level_priority_reg,
      .global_irq_enable_instr, .global_irq_disable_instr, .reset_addr_opt,
      .reset_addr_alt, .cpu_ack, .rom_rdata, .cpu_req, .rom_fetch,
      .push_context, .service_valid, .service_addr, .reset_pc,
      .system_mode_reg, .level_pending, .src_pending
   );
   cpu_core_model cpu_core_model_inst (
      .clk, .rst_n, .ack_wait, .cpu_req, .rom_fetch, .cpu_ack, .rom_rdata
   );

   task automatic tick(int n = 1);
      repeat (n) @(posedge clk);
      #10;
   endtask
   task automatic chk(logic [23:0] got, logic [23:0] exp);
      total_checks++;
      if (got !== exp) begin
         failures++;
         $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic report_and_stop;
      $display("checks %0d failures %0d", total_checks, failures);
      if (failures == 0 && total_checks > 0) $display("DONE - PASS");
      else $display("DONE - FAIL");
      $finish;
   endtask
   task automatic ev(logic [13:0] m);
      periph_event = m;
      tick();
      periph_event = 14'h0000;
   endtask
   task automatic gie_on;
      global_irq_enable_instr = 1'b1;
      tick();
      global_irq_enable_instr = 1'b0;
   endtask
   function automatic logic [2:0] lv(int i);
      if (i < 2) return 3'h0;
      if (i < 4) return 3'(i - 1);
      if (i < 8) return 3'h3;
      if (i < 10) return 3'h4;
      return 3'(5 + (i - 10) / 4);
   endfunction
   function automatic logic [1:0] pr(int i);
      if (i < 2) return 2'(i);
      if (i < 4) return 2'h0;
      if (i < 10) return 2'(i - (i < 8 ? 4 : 8));
      return 2'((i - 10) % 4);
   endfunction

   // one full grant of source i, then software clear of its flag
   task automatic serve(int i);
      int         n;
      logic [7:0] v;
      v = i < 14 ? VT[i] : 8'hF0 + 8'(2 * (i - 14));
      ack_wait = 2'(i);
      gie_on();
      chk(system_mode_reg[0], 1'b1);
      for (n = 0; n < 60 && cpu_req.valid !== 1'b1; n++) tick();
      if (n == 60) failures++;
      if (n == 60) report_and_stop();
      chk(cpu_req.vector, v);
      chk(cpu_req.level, lv(i));
      chk(cpu_req.prio, pr(i));
      for (n = 0; n < 60 && service_valid !== 1'b1; n++) tick();
      if (n == 60) failures++;
      if (n == 60) report_and_stop();
      chk(service_addr, {v ^ 8'h5A, (v + 8'h01) ^ 8'h5A});
      chk(system_mode_reg, 8'h00);
      chk(src_pending[i], i >= 8);
      sw_pend_clear[i] = 1'b1;
      tick();
      sw_pend_clear = 22'h000000;
      tick();
      chk(src_pending[i], 1'b0);
   endtask

   initial begin
      tick(16);
      rst_n = 1'b1;
      tick();
      chk(reset_pc, 16'h0100);
      chk(system_mode_reg, 8'h00);
      ev(14'h2000);
      tick(4);
      chk(cpu_req.valid, 1'b0);
      chk(src_pending[13], 1'b1);
      chk(level_pending, 8'h20);
      serve(13);
      for (int i = 0; i < 22; i++) begin
         if (i < 14) ev(14'h0001 << i);
         else ext_pin[i-14] = 1'b1;
         serve(i);
      end
      // falling edges under rising select must stay silent
      ext_pin = 8'h00;
      tick(6);
      chk(src_pending, 22'h000000);
      ev(14'h00F0);
      for (int i = 4; i < 8; i++) serve(i);
      level_priority_reg = 24'hFC7FFF;
      ev(14'h0401);
      serve(10);
      serve(0);
      level_priority_reg = 24'h000000;
      ev(14'h0004);
      level_mask_reg = 8'hFD;
      gie_on();
      tick(5);
      chk(cpu_req.valid, 1'b0);
      level_mask_reg = 8'hFF;
      src_enable[2] = 1'b0;
      tick(5);
      chk(cpu_req.valid, 1'b0);
      // disable first so re-enabling the source cannot race a grant
      global_irq_disable_instr = 1'b1;
      tick();
      global_irq_disable_instr = 1'b0;
      src_enable[2] = 1'b1;
      tick(5);
      chk(cpu_req.valid, 1'b0);
      serve(2);
      ext_rising_sel[0] = 1'b0;
      tick();
      ext_pin[0] = 1'b1;
      tick(8);
      chk(src_pending[14], 1'b0);
      ext_pin[0] = 1'b0;
      tick(8);
      chk(src_pending[14], 1'b1);
      serve(14);
      reset_addr_opt = 1'b1;
      reset_addr_alt = 16'h2468;
      rst_n = 1'b0;
      tick(2);
      rst_n = 1'b1;
      tick(2);
      chk(reset_pc, 16'h2468);
      report_and_stop();
   end
endmodule
